// File: rtl/bfp_ctrl.sv
`timescale 1ns/100ps
// Notes on behaviour
// - One current-level select sets both high-side and low-side limits together.
// - High-side peak trip turns high side off and low side on at once.
// - High side stays off until current falls below low-side limit.
// - Fifteen consecutive tripped cycles enter hiccup; untripped cycle clears count.
// - Low-side sourcing comparator sampled at cycle end withholds next cycle.
// - Low-side sink limit trip turns both switches off immediately.
// - Output undervoltage shuts switching down.
// - Persisting undervoltage after a wait starts a new soft-start.
// - Overvoltage holds high side off, low side on until sink limit.
// - Overvoltage recovery deasserting restarts through full soft-start.
// - Over-temperature flag stops all switching.
// - Over-temperature clearing resumes with complete soft-start.
// - Discharge switch closes on undervoltage, over-temperature, overcurrent, input lockout.
// - First sixteen soft-start cycles run discontinuous, blocking reverse current.
// - Afterwards zero-detect level steps toward negative current until it reaches BFP_ZCD_MAX or soft-start ends.
// - After soft-start, forced continuous mode holds in normal operation.
// - High-side comparator ignored for a blanking delay after turn-on.
// - Power-good pulled low on undervoltage, overvoltage, over-temperature or hiccup after start-up, not on cycle-by-cycle current limits.
module bfp_ctrl #(
    parameter int UV_WAIT_CYC  = 1024,
    parameter int HICCUP_CYC   = 2048,
    parameter int SOFT_CYC     = 256
) (
    input  wire logic                       ref_clk_i,
    input  wire logic                       nrst_i,
    input  wire logic                       enable_i,
    input  wire logic                       in_uvlo_i,
    input  wire logic                       cur_level_high_i,
    input  wire logic                       cycle_tick_i,
    input  wire logic                       pwm_off_i,
    input  wire bfp_pkg::bfp_cmp_t          cmp_i,
    output logic                            hs_limit_high_o,
    output logic                            ls_limit_high_o,
    output bfp_pkg::bfp_gate_t              gate_o,
    output logic [bfp_pkg::BFP_ZCD_W-1:0]   zcd_level_o,
    output logic                            forced_continuous_mode_o,
    output logic                            power_ok_output_oe_o,
    output logic                            power_ok_output_o,
    output logic                            hiccup_o
);
    import bfp_pkg::*;

    // Two-stage synchronisers for all asynchronous pins
    localparam int NSYNC = 13;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    logic [NSYNC-1:0] raw_in;
    assign raw_in = {enable_i, in_uvlo_i, cur_level_high_i, pwm_off_i, cmp_i};

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    logic     en_s;
    logic     uvlo_s;
    logic     lvl_s;
    logic     pwm_off_s;
    bfp_cmp_t c;
    assign {en_s, uvlo_s, lvl_s, pwm_off_s, c} = sync_b;

    // Tick is an on-chip enable from the same clock, used directly
    logic tick;
    assign tick = cycle_tick_i;

    bfp_state_t             st;
    bfp_state_t             next_st;
    bfp_phase_t             ph;
    bfp_phase_t             next_ph;
    logic [BFP_CNT_W-1:0]   tmr;
    logic [BFP_CNT_W-1:0]   next_tmr;
    logic [BFP_CNT_W-1:0]   scyc;
    logic [BFP_CNT_W-1:0]   next_scyc;
    logic [4:0]             oc_cnt;
    logic [4:0]             next_oc_cnt;
    logic                   trip_seen;
    logic                   next_trip_seen;
    logic [3:0]             blank;
    logic [3:0]             next_blank;
    logic [3:0]             on_cnt;
    logic [3:0]             next_on_cnt;
    logic [BFP_ZCD_W-1:0]   zcd;
    logic [BFP_ZCD_W-1:0]   next_zcd;
    bfp_gate_t              gate;
    bfp_gate_t              next_gate;
    logic                   pg_low;
    logic                   next_pg_low;
    logic                   lvl;
    logic                   next_lvl;
    logic                   forced_continuous_mode;
    logic                   next_forced_continuous_mode;
    logic                   fault;
    logic                   hic;
    logic                   next_hic;

    // Start-up gating: enable low or input lockout resets to off
    logic stop_all;
    assign stop_all = !en_s || uvlo_s;

    // Master state and switching phase
    always_comb begin
        next_st        = st;
        next_ph        = ph;
        next_tmr       = tmr;
        next_scyc      = scyc;
        next_oc_cnt    = oc_cnt;
        next_trip_seen = trip_seen;
        next_blank     = (blank != 4'h0) ? blank - 4'h1 : blank;
        next_on_cnt    = on_cnt;
        next_zcd       = zcd;
        next_forced_continuous_mode      = forced_continuous_mode;
        next_gate      = gate;
        next_gate.discharge = 1'b0;
        fault          = 1'b0;
        if (stop_all) begin
            next_st   = ST_OFF;
            next_ph   = PH_IDLE;
            // Overheat keeps discharging even while disabled
            next_gate = '{high_side_switch: 1'b0, low_side_switch: 1'b0,
                          discharge: uvlo_s || c.over_temp};
            next_forced_continuous_mode = 1'b0;
            next_oc_cnt = '0;
        end else if (c.over_temp) begin
            next_st   = ST_OTP;
            next_ph   = PH_IDLE;
            next_gate = '{high_side_switch: 1'b0, low_side_switch: 1'b0, discharge: 1'b1};
            fault     = 1'b1;
        end else if (c.fb_ov && st != ST_OVP) begin
            next_st   = ST_OVP;
            next_ph   = PH_HOLD;
            next_gate = '{high_side_switch: 1'b0, low_side_switch: !c.ls_sink, discharge: 1'b0};
            fault     = 1'b1;
        end else if (c.out_uv && (st == ST_RUN || st == ST_SOFT)) begin
            next_st   = ST_UVW;
            next_tmr  = '0;
            next_ph   = PH_IDLE;
            next_gate = '{high_side_switch: 1'b0, low_side_switch: 1'b0, discharge: 1'b1};
            fault     = 1'b1;
        end else begin
            case (st)
                ST_OFF, ST_OTP: begin
                    next_st   = ST_SOFT;
                    next_scyc = '0;
                    next_zcd  = BFP_ZCD_ZERO;
                    next_forced_continuous_mode = 1'b0;
                    next_ph   = PH_IDLE;
                    next_gate = '0;
                end
                ST_OVP: begin
                    fault = 1'b1;
                    next_gate.high_side_switch = 1'b0;
                    if (c.ls_sink) next_gate.low_side_switch = 1'b0;
                    if (!c.fb_ov_rec) next_st = ST_OFF;
                end
                ST_UVW, ST_HICC: begin
                    fault     = 1'b1;
                    next_gate = '{high_side_switch: 1'b0, low_side_switch: 1'b0, discharge: 1'b1};
                    if (tick) next_tmr = tmr + 1'b1;
                    if (st == ST_UVW && tmr >= BFP_CNT_W'(UV_WAIT_CYC)) next_st = ST_OFF;
                    if (st == ST_HICC && tmr >= BFP_CNT_W'(HICCUP_CYC)) next_st = ST_OFF;
                end
                default: begin
                    // Soft-start and run share the switching phase engine
                    if (tick) begin
                        next_trip_seen = 1'b0;
                        next_oc_cnt = trip_seen ? oc_cnt + 5'h1 : 5'h0;
                        if (st == ST_SOFT) begin
                            next_scyc = scyc + 1'b1;
                            if (scyc >= BFP_CNT_W'(BFP_DCM_CYCLES) && zcd != BFP_ZCD_MAX)
                                next_zcd = zcd + 1'b1;
                            if (scyc >= BFP_CNT_W'(SOFT_CYC)) begin
                                next_st   = ST_RUN;
                                next_forced_continuous_mode = 1'b1;
                            end
                        end
                        if (!c.ls_source && ph != PH_HOLD) begin
                            next_ph     = PH_HIGH;
                            next_gate   = '{high_side_switch: 1'b1, low_side_switch: 1'b0,
                                            discharge: 1'b0};
                            next_blank  = 4'(BFP_BLANK_CYC);
                            next_on_cnt = 4'(BFP_ON_CYCLES);
                        end else if (ph != PH_HOLD) begin
                            next_ph   = PH_LOW;
                            next_gate = '{high_side_switch: 1'b0, low_side_switch: 1'b1,
                                          discharge: 1'b0};
                        end
                    end else begin
                        case (ph)
                            PH_HIGH: begin
                                if (on_cnt != 4'h0) next_on_cnt = on_cnt - 4'h1;
                                if (blank == 4'h0 && c.hs_peak) begin
                                    next_ph        = PH_HOLD;
                                    next_trip_seen = 1'b1;
                                    next_gate      = '{high_side_switch: 1'b0,
                                                       low_side_switch: 1'b1, discharge: 1'b0};
                                end else if (pwm_off_s || on_cnt == 4'h0) begin
                                    next_ph   = PH_LOW;
                                    next_gate = '{high_side_switch: 1'b0,
                                                  low_side_switch: 1'b1, discharge: 1'b0};
                                end
                            end
                            PH_HOLD: begin
                                if (c.ls_below) next_ph = PH_LOW;
                            end
                            PH_LOW: begin
                                if (st == ST_SOFT && scyc < BFP_CNT_W'(BFP_DCM_CYCLES)
                                    && c.zero_cross)
                                    next_gate.low_side_switch = 1'b0;
                            end
                            default: next_ph = PH_IDLE;
                        endcase
                    end
                    if (c.ls_sink) begin
                        next_gate.high_side_switch = 1'b0;
                        next_gate.low_side_switch  = 1'b0;
                    end
                    if (next_oc_cnt >= 5'(BFP_HICCUP_COUNT)) begin
                        next_st     = ST_HICC;
                        next_tmr    = '0;
                        next_oc_cnt = '0;
                        next_ph     = PH_IDLE;
                        next_gate   = '{high_side_switch: 1'b0, low_side_switch: 1'b0,
                                        discharge: 1'b1};
                    end
                end
            endcase
        end
        if (fault && next_st != ST_OVP && st != ST_OVP) next_gate.discharge = 1'b1;
        if (uvlo_s) next_gate.discharge = 1'b1;
        next_pg_low = (next_st != ST_RUN) || fault;
        next_lvl = lvl_s;
        // Hiccup flag registered beside the state
        next_hic = (next_st == ST_HICC);
    end

    always_ff @(posedge ref_clk_i) begin
        if (!nrst_i) begin
            st        <= ST_OFF;
            ph        <= PH_IDLE;
            tmr       <= '0;
            scyc      <= '0;
            oc_cnt    <= '0;
            trip_seen <= 1'b0;
            blank     <= '0;
            on_cnt    <= '0;
            zcd       <= BFP_ZCD_ZERO;
            gate      <= '0;
            pg_low    <= 1'b1;
            lvl       <= 1'b0;
            forced_continuous_mode      <= 1'b0;
            hic       <= 1'b0;
        end else begin
            st        <= next_st;
            ph        <= next_ph;
            tmr       <= next_tmr;
            scyc      <= next_scyc;
            oc_cnt    <= next_oc_cnt;
            trip_seen <= next_trip_seen;
            blank     <= next_blank;
            on_cnt    <= next_on_cnt;
            zcd       <= next_zcd;
            gate      <= next_gate;
            pg_low    <= next_pg_low;
            lvl       <= next_lvl;
            forced_continuous_mode      <= next_forced_continuous_mode;
            hic       <= next_hic;
        end
    end

    // All outputs straight from flops, except power_ok_output_o tied low
    assign hs_limit_high_o          = lvl;
    assign ls_limit_high_o          = lvl;
    assign gate_o                   = gate;
    assign zcd_level_o              = zcd;
    assign forced_continuous_mode_o = forced_continuous_mode;
    assign power_ok_output_oe_o     = pg_low;
    assign power_ok_output_o        = 1'b0;
    assign hiccup_o                 = hic;

endmodule

// File: rtl/bfp_pkg.sv
package bfp_pkg;

    // Comparator inputs from the analog side
    typedef struct packed {
        logic hs_peak;      // High-side peak current limit tripped
        logic ls_source;    // Low-side sourcing current above limit
        logic ls_sink;      // Low-side sink limit reached
        logic ls_below;     // Inductor current below low-side limit
        logic fb_ov;        // Feedback above overvoltage trip
        logic fb_ov_rec;    // Feedback still above recovery level
        logic out_uv;       // Output below undervoltage threshold
        logic over_temp;    // Over-temperature flag
        logic zero_cross;   // Inductor current at zero-detect level
    } bfp_cmp_t;

    // Gate and discharge commands
    typedef struct packed {
        logic high_side_switch;
        logic low_side_switch;
        logic discharge;
    } bfp_gate_t;

    localparam int  BFP_HICCUP_COUNT = 15;
    localparam int  BFP_DCM_CYCLES   = 16;
    localparam int  BFP_CNT_W        = 16;
    localparam int  BFP_ZCD_W        = 4;
    localparam logic [BFP_ZCD_W-1:0] BFP_ZCD_ZERO = 4'h0;
    localparam logic [BFP_ZCD_W-1:0] BFP_ZCD_MAX  = 4'hF;

    // Blanking after high-side turn-on
    localparam int  BFP_BLANK_NS     = 60;
    localparam int  BFP_CLK_MHZ      = 50;
    localparam int  BFP_BLANK_CYC    = (BFP_BLANK_NS * BFP_CLK_MHZ + 999) / 1000;
    localparam int  BFP_ON_CYCLES    = 8;

    typedef enum logic [2:0] {
        ST_OFF   = 3'h0,
        ST_SOFT  = 3'h1,
        ST_RUN   = 3'h2,
        ST_HICC  = 3'h3,
        ST_UVW   = 3'h4,
        ST_OVP   = 3'h5,
        ST_OTP   = 3'h6
    } bfp_state_t;

    typedef enum logic [1:0] {
        PH_IDLE  = 2'h0,
        PH_HIGH  = 2'h1,
        PH_LOW   = 2'h2,
        PH_HOLD  = 2'h3
    } bfp_phase_t;

endpackage

// File: test/bfp_ctrl_asserts.sv
`timescale 1ns/100ps
module bfp_ctrl_asserts (
    input wire logic               ref_clk_i,
    input wire logic               nrst_i,
    input wire logic               enable_i,
    input wire logic               in_uvlo_i,
    input wire logic               cur_level_high_i,
    input wire bfp_pkg::bfp_cmp_t  cmp_i,
    input wire logic               hs_limit_high_o,
    input wire logic               ls_limit_high_o,
    input wire bfp_pkg::bfp_gate_t gate_o,
    input wire logic               power_ok_output_oe_o,
    input wire logic               power_ok_output_o,
    input wire logic               hiccup_o
);
    import bfp_pkg::*;
    logic [2:0] up_cnt;
    logic [2:0] next_up_cnt;
    logic       hs;
    logic       ls;
    // Short names for the two gates
    assign hs = gate_o.high_side_switch;
    assign ls = gate_o.low_side_switch;
    // Cycles since reset, saturating, so synchroniser flush is not judged
    always_comb begin
        next_up_cnt = up_cnt + 3'(up_cnt != 3'h7);
    end
    always_ff @(posedge ref_clk_i) begin
        up_cnt <= nrst_i ? next_up_cnt : 3'h0;
    end
    default clocking cb @(posedge ref_clk_i);
    endclocking
    default disable iff (!nrst_i);
    // High side well past blanking, then a peak trip seen twice
    sequence s_hs_on;
        hs[*3];
    endsequence
    sequence s_peak;
        (hs && cmp_i.hs_peak)[*2];
    endsequence
    chk_limit_follow: assert property (
        (up_cnt == 3'h7 && $stable(cur_level_high_i))[*5] |-> hs_limit_high_o == cur_level_high_i)
        else $error("limit select not followed");
    chk_limit_pair: assert property (hs_limit_high_o == ls_limit_high_o)
        else $error("limits differ");
    chk_peak_cut: assert property (s_hs_on ##1 s_peak |-> ##2 (!hs && ls))
        else $error("peak trip did not swap switches");
    chk_src_block: assert property ($rose(hs) |->
        !($past(cmp_i.ls_source, 2) && $past(cmp_i.ls_source, 3) && $past(cmp_i.ls_source, 4)))
        else $error("cycle started under source limit");
    chk_sink_off: assert property (cmp_i.ls_sink[*4] |-> !hs && !ls)
        else $error("sink limit left a switch on");
    chk_ovp_hold: assert property ((cmp_i.fb_ov && !cmp_i.ls_sink)[*4] |-> !hs)
        else $error("high side on in overvoltage");
    chk_otp_off: assert property (cmp_i.over_temp[*4] |->
        !hs && !ls && gate_o.discharge && power_ok_output_oe_o)
        else $error("switching in over-temperature");
    chk_uvlo_dis: assert property (in_uvlo_i[*5] |-> gate_o.discharge)
        else $error("no discharge in input lockout");
    chk_hiccup_dis: assert property (hiccup_o |-> gate_o.discharge && !hs && power_ok_output_oe_o)
        else $error("hiccup without discharge");
    chk_uv_stop: assert property ($rose(cmp_i.out_uv) ##0
        (cmp_i.out_uv && enable_i && !in_uvlo_i)[*4] |-> !hs && gate_o.discharge)
        else $error("undervoltage did not stop switching");
    chk_pg_data: assert property (power_ok_output_o == 1'b0)
        else $error("power-good data not low");
endmodule
bind bfp_ctrl bfp_ctrl_asserts u_bfp_ctrl_asserts (
    .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .enable_i(enable_i), .in_uvlo_i(in_uvlo_i),
    .cur_level_high_i(cur_level_high_i), .cmp_i(cmp_i), .hs_limit_high_o(hs_limit_high_o),
    .ls_limit_high_o(ls_limit_high_o), .gate_o(gate_o), .hiccup_o(hiccup_o),
    .power_ok_output_oe_o(power_ok_output_oe_o), .power_ok_output_o(power_ok_output_o)
);

// File: test/bfp_stage_model.sv
`timescale 1ns/100ps
module bfp_stage_model (
    input  wire logic               ref_clk_i,
    input  wire bfp_pkg::bfp_gate_t gate_i,
    input  wire bfp_pkg::bfp_cmp_t  force_i,
    input  wire logic               peak_en_i,
    input  wire logic               below_blk_i,
    output logic                    tick_o,
    output logic                    pwm_off_o,
    output bfp_pkg::bfp_cmp_t       cmp_o
);
    import bfp_pkg::*;
    logic [4:0] tcnt   = 5'h00;
    logic [3:0] on_cnt = 4'h0;
    logic [3:0] lo_cnt = 4'h0;
    // Oscillator and crude inductor timing, moved off the sampling edge
    always @(negedge ref_clk_i) begin
        tcnt <= (tcnt == 5'h13) ? 5'h00 : tcnt + 5'h01;
        on_cnt <= gate_i.high_side_switch ? on_cnt + 4'(on_cnt != 4'hF) : 4'h0;
        lo_cnt <= gate_i.low_side_switch ? lo_cnt + 4'(lo_cnt != 4'hF) : 4'h0;
    end
    // Peak beats the PWM end by a cycle so trips are really taken
    assign tick_o    = (tcnt == 5'h00);
    assign pwm_off_o = (on_cnt >= 4'h4);
    assign cmp_o = force_i | bfp_cmp_t'{hs_peak: peak_en_i && on_cnt >= 4'h3,
        ls_below: lo_cnt >= 4'h2 && !below_blk_i, zero_cross: lo_cnt >= 4'h3, default: 1'b0};
endmodule

// File: test/tb_bfp_ctrl.sv
`timescale 1ns/100ps
module tb_bfp_ctrl;
    import bfp_pkg::*;
    logic        ref_clk_i = 1'b0;
    logic        nrst_i;
    logic        en;
    logic        uvlo;
    logic        lvl;
    logic        peak_en;
    logic        blk;
    bfp_cmp_t    frc;
    bfp_cmp_t    cmp;
    bfp_gate_t   gate;
    logic        tick;
    logic        pwm_off;
    logic        lim_hs;
    logic        lim_ls;
    logic [3:0]  zcd;
    logic        forced_continuous_mode;
    logic        pg_oe;
    logic        hic;
    logic        hs_d = 1'b0;
    int          n_on = 0;
    int          n_fail = 0;
    int          cmp_count = 0;
    int          base;
    logic [31:0] seed = 32'hBA7D;

    always #10 ref_clk_i = ~ref_clk_i;
    // Count turn-ons to see whether cycles really start
    always @(posedge ref_clk_i) begin
        hs_d <= gate.high_side_switch;
        if (gate.high_side_switch && !hs_d)
            n_on <= n_on + 1;
    end
    bfp_stage_model u_bfp_stage_model (.ref_clk_i(ref_clk_i), .gate_i(gate), .force_i(frc),
        .peak_en_i(peak_en), .below_blk_i(blk), .tick_o(tick), .pwm_off_o(pwm_off), .cmp_o(cmp));
    // Short counts so soft-start, hiccup and recovery fit the run
    bfp_ctrl #(.UV_WAIT_CYC(4), .HICCUP_CYC(4), .SOFT_CYC(40)) u_bfp_ctrl (
        .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .enable_i(en), .in_uvlo_i(uvlo),
        .cur_level_high_i(lvl), .cycle_tick_i(tick), .pwm_off_i(pwm_off), .cmp_i(cmp),
        .hs_limit_high_o(lim_hs), .ls_limit_high_o(lim_ls), .gate_o(gate), .zcd_level_o(zcd),
        .forced_continuous_mode_o(forced_continuous_mode), .power_ok_output_oe_o(pg_oe),
        .power_ok_output_o(), .hiccup_o(hic));

    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] x;
        x = s ^ (s << 13);
        x = x ^ (x >> 17);
        return x ^ (x << 5);
    endfunction
    // Hiccup is due once the run of tripped cycles reaches the limit
    function automatic logic hic_exp(input int trips);
        return trips >= BFP_HICCUP_COUNT;
    endfunction
    task automatic chk(input string nm, input logic [7:0] seen, input logic [7:0] exp);
        cmp_count++;
        if (seen !== exp) begin
            n_fail++;
            $display("Error %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    task automatic results;
        $display("Comparisons %0d, mismatches %0d", cmp_count, n_fail);
        if (n_fail == 0 && cmp_count > 0) begin
            $display("Run complete: PASS");
        end else begin
            $display("Run complete: FAIL");
        end
        $finish;
    endtask
    task automatic clk(input int n);
        repeat (n) @(negedge ref_clk_i);
    endtask
    // The stage model ticks every 20 clocks
    task automatic ticks(input int n);
        clk(20 * n);
    endtask
    // Bounded wait for the hand-over to normal operation
    task automatic up;
        int k;
        for (k = 0; k < 3000 && forced_continuous_mode !== 1'b1; k++)
            clk(1);
        if (k == 3000) begin
            n_fail++;
            results();
        end
    endtask

    initial begin
        nrst_i = 1'b0; en = 1'b0; uvlo = 1'b1; lvl = 1'b0; peak_en = 1'b0; blk = 1'b0; frc = '0;
        clk(16);
        nrst_i = 1'b1;
        clk(6);
        chk("dis_uvlo", gate.discharge, 1);
        uvlo = 1'b0;
        repeat (8) begin
            seed = xs(seed);
            lvl = seed[0];
            clk(5);
            chk("lim_pair", {lim_hs, lim_ls}, {2{lvl}});
        end
        en = 1'b1;
        ticks(8);
        // Late in a cycle, after zero cross the low side must be off
        clk(15);
        chk("dcm_zcd", {zcd, forced_continuous_mode, pg_oe, gate.low_side_switch}, 8'h02);
        ticks(20);
        chk("zcd_step", zcd != 4'h0 && zcd != 4'hF, 1);
        up();
        chk("run_pg", {forced_continuous_mode, pg_oe}, 8'h02);
        frc.ls_source = 1'b1;
        clk(4);
        base = n_on;
        ticks(3);
        chk("src_hold", 8'(n_on - base), 0);
        frc.ls_source = 1'b0;
        ticks(2);
        chk("src_free", n_on > base, 1);
        peak_en = 1'b1; blk = 1'b1;
        ticks(1);
        base = n_on;
        ticks(3);
        chk("peak_hold", 8'(n_on - base), 0);
        blk = 1'b0; peak_en = 1'b0;
        ticks(3);
        seed = xs(seed);
        peak_en = 1'b1;
        ticks(6 + int'(seed[2:0]));
        peak_en = 1'b0;
        ticks(2);
        chk("no_hiccup", hic, hic_exp(6 + int'(seed[2:0])));
        peak_en = 1'b1;
        ticks(13);
        chk("cnt_clear", hic, hic_exp(12));
        ticks(4);
        chk("hiccup", {hic, gate}, {hic_exp(15), 3'b001});
        peak_en = 1'b0;
        ticks(6);
        chk("hic_retry", forced_continuous_mode, 0);
        up();
        frc.fb_ov = 1'b1; frc.fb_ov_rec = 1'b1;
        clk(6);
        chk("ovp_gate", {gate.high_side_switch, gate.low_side_switch, pg_oe}, 8'h03);
        frc.ls_sink = 1'b1;
        clk(6);
        chk("sink_off", {gate.high_side_switch, gate.low_side_switch}, 0);
        frc = '0;
        ticks(3);
        chk("ovp_soft", forced_continuous_mode, 0);
        up();
        frc.over_temp = 1'b1;
        clk(6);
        chk("otp_gate", {gate, pg_oe}, 8'h03);
        base = n_on;
        ticks(3);
        chk("otp_idle", 8'(n_on - base), 0);
        frc.over_temp = 1'b0;
        ticks(4);
        chk("otp_soft", {n_on > base, forced_continuous_mode}, 8'h02);
        up();
        frc.out_uv = 1'b1;
        clk(6);
        chk("uv_gate", {gate.high_side_switch, gate.discharge}, 8'h01);
        base = n_on;
        ticks(2);
        chk("uv_idle", 8'(n_on - base), 0);
        frc.out_uv = 1'b0;
        ticks(6);
        chk("uv_soft", {n_on > base, forced_continuous_mode}, 8'h02);
        up();
        results();
    end
endmodule
